// ==== logic/cogr_map.vh ====
// Register map, field positions and reset values of the colour offset/gain bank
`ifndef COGR_MAP_VH
`define COGR_MAP_VH

// Register addresses (4-bit word address)
`define COGR_ADDR_CTRL       4'h0
`define COGR_ADDR_TEST       4'h1
`define COGR_ADDR_OFS_RED    4'h2
`define COGR_ADDR_OFS_GREEN  4'h3
`define COGR_ADDR_OFS_BLUE   4'h4
`define COGR_ADDR_OFS_ALL    4'h5
`define COGR_ADDR_GAIN_RED   4'h6
`define COGR_ADDR_GAIN_GREEN 4'h7
`define COGR_ADDR_GAIN_BLUE  4'h8
`define COGR_ADDR_GAIN_ALL   4'h9
`define COGR_ADDR_STATUS     4'ha

// Control and test register fields
`define COGR_SEL_LSB         4
`define COGR_SEL_MSB         5
`define COGR_CLKTEST_BIT     7

// Status register fields
`define COGR_STAT_SEL_LSB    0
`define COGR_STAT_SEL_MSB    1
`define COGR_STAT_CLKTEST    2
`define COGR_STAT_RSVD_SEL   3

// Colour selection codes
`define COGR_SEL_RED         2'h0
`define COGR_SEL_GREEN       2'h1
`define COGR_SEL_BLUE        2'h2
`define COGR_SEL_RSVD        2'h3

// Reset values
`define COGR_RST_OFFSET      8'h80
`define COGR_RST_GAIN        8'h00
`define COGR_RST_CTRL        8'h00
`define COGR_RST_TEST        8'h00
`define COGR_RST_NIBBLE      4'h0

// Gain equation in thousandths: 780 + code * 7570 / 255
`define COGR_GAIN_BASE_MILLI 14'h030c
`define COGR_GAIN_STEP_MILLI 13'h1d92
`define COGR_GAIN_DIVISOR    21'h0_00ff

`endif

// ==== logic/cogr_gain_calc.v ====
// Converts an 8-bit gain code into the applied gain in thousandths
`timescale 1ns/1ps
`default_nettype none
`include "cogr_map.vh"

module cogr_gain_calc
(
  // Clock and reset
  input  wire        mclk_i,
  input  wire        srst_i,
  // Code in, gain out
  input  wire [7:0]  code_i,
  output reg  [13:0] gain_milli_o
);

  wire [20:0] product;
  wire [20:0] quotient;
  wire [13:0] next_gain_milli;

  assign product         = {13'h0000, code_i} * {8'h00, `COGR_GAIN_STEP_MILLI};
  assign quotient        = product / `COGR_GAIN_DIVISOR;
  assign next_gain_milli = `COGR_GAIN_BASE_MILLI + quotient[13:0];

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      gain_milli_o <= `COGR_GAIN_BASE_MILLI;
    end
    else
    begin
      gain_milli_o <= next_gain_milli;
    end
  end

endmodule
`default_nettype wire

// ==== logic/cogr_out_mux.v ====
// Output nibble multiplexer: converted data or internal timing in clock test mode
`timescale 1ns/1ps
`default_nettype none
`include "cogr_map.vh"

module cogr_out_mux
(
  // Clock and reset
  input  wire       mclk_i,
  input  wire       srst_i,
  // Mode
  input  wire       clock_test_enable_i,
  // Sources
  input  wire [3:0] conv_data_i,
  input  wire       int_sample_pulse_i,
  input  wire       video_sample_clk_i,
  input  wire       converter_clk_i,
  input  wire       reset_sample_clk_i,
  // Pins
  output reg  [3:0] nibble_output_o
);

  wire [3:0] next_nibble;

  assign next_nibble = clock_test_enable_i ?
                       {int_sample_pulse_i, video_sample_clk_i,
                        converter_clk_i, reset_sample_clk_i} :
                       conv_data_i;

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      nibble_output_o <= `COGR_RST_NIBBLE;
    end
    else
    begin
      nibble_output_o <= next_nibble;
    end
  end

endmodule
`default_nettype wire

// ==== logic/cogr_regs.v ====
// Colour offset and gain register bank with colour selection and test output mux
//
// Summary of operation
// RULE1: The red offset holds 8 bits, resets to 0x80 and is applied when red is selected.
// RULE2: The green offset holds 8 bits, resets to 0x80 and is applied when green is selected.
// RULE3: The blue offset holds 8 bits, resets to 0x80 and is applied when blue is selected.
// RULE4: Writing the broadcast offset loads one value into all three offsets at once.
// RULE5: The red gain code resets to zero and gives 0.78 + code*7.57/255 when red is selected.
// RULE6: The green gain code resets to zero and gives 0.78 + code*7.57/255 for green.
// RULE7: The blue gain code resets to zero and gives 0.78 + code*7.57/255 for blue.
// RULE8: Writing the broadcast gain loads one code into all three gain codes at once.
// RULE9: Colour select 00 picks red, 01 green, 10 blue, and 11 is reserved.
// RULE10: With clock test set, the nibble output carries timing, bit 1 converter clock, bit 0 reset sample clock.
// RULE11: The broadcast locations are write-only and their read value is not to be relied on.
`timescale 1ns/1ps
`default_nettype none
`include "cogr_map.vh"

module cogr_regs
(
  // Clock and reset
  input  wire        mclk_i,
  input  wire        srst_i,
  // Register port
  input  wire [3:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  // Converted data and internal timing, same clock domain
  input  wire [3:0]  conv_data_i,
  input  wire        int_sample_pulse_i,
  input  wire        video_sample_clk_i,
  input  wire        converter_clk_i,
  input  wire        reset_sample_clk_i,
  // Applied values towards the signal path
  output reg  [7:0]  active_offset_o,
  output reg  [7:0]  active_gain_code_o,
  output wire [13:0] active_gain_milli_o,
  output reg  [1:0]  active_colour_o,
  // Output pins
  output wire [3:0]  nibble_output_o
);

  // Picks one of three colour values by selection code
  function [7:0] cogr_pick;
    input [1:0] sel;
    input [7:0] red_val;
    input [7:0] green_val;
    input [7:0] blue_val;
    begin
      case (sel)
        `COGR_SEL_RED:
        begin
          cogr_pick = red_val;
        end
        `COGR_SEL_GREEN:
        begin
          cogr_pick = green_val;
        end
        `COGR_SEL_BLUE:
        begin
          cogr_pick = blue_val;
        end
        default:
        begin
          cogr_pick = red_val;
        end
      endcase
    end
  endfunction

  // Write strobe for one address
  function cogr_wr_hit;
    input       wr;
    input [3:0] addr;
    input [3:0] target;
    begin
      cogr_wr_hit = wr && (addr == target);
    end
  endfunction

  // Register storage
  reg  [7:0] red_offset_code;
  reg  [7:0] green_offset_code;
  reg  [7:0] blue_offset_code;
  reg  [7:0] red_gain_code;
  reg  [7:0] green_gain_code;
  reg  [7:0] blue_gain_code;
  reg  [7:0] ctrl_reg;
  reg  [7:0] test_reg;
  reg        rsvd_sel_seen;

  // Decoded write strobes and the status read strobe
  wire       wr_ofs_red;
  wire       wr_ofs_green;
  wire       wr_ofs_blue;
  wire       wr_ofs_all;
  wire       wr_gain_red;
  wire       wr_gain_green;
  wire       wr_gain_blue;
  wire       wr_gain_all;
  wire       wr_ctrl;
  wire       wr_test;
  wire       rd_status;

  // Derived fields
  wire [1:0] colour_select;
  wire       clock_test_enable;
  wire [7:0] status_word;
  reg  [1:0] next_active_colour;
  reg  [7:0] next_rdata;

  assign wr_ofs_red    = cogr_wr_hit(wr_i, addr_i, `COGR_ADDR_OFS_RED);
  assign wr_ofs_green  = cogr_wr_hit(wr_i, addr_i, `COGR_ADDR_OFS_GREEN);
  assign wr_ofs_blue   = cogr_wr_hit(wr_i, addr_i, `COGR_ADDR_OFS_BLUE);
  assign wr_ofs_all    = cogr_wr_hit(wr_i, addr_i, `COGR_ADDR_OFS_ALL);
  assign wr_gain_red   = cogr_wr_hit(wr_i, addr_i, `COGR_ADDR_GAIN_RED);
  assign wr_gain_green = cogr_wr_hit(wr_i, addr_i, `COGR_ADDR_GAIN_GREEN);
  assign wr_gain_blue  = cogr_wr_hit(wr_i, addr_i, `COGR_ADDR_GAIN_BLUE);
  assign wr_gain_all   = cogr_wr_hit(wr_i, addr_i, `COGR_ADDR_GAIN_ALL);
  assign wr_ctrl       = cogr_wr_hit(wr_i, addr_i, `COGR_ADDR_CTRL);
  assign wr_test       = cogr_wr_hit(wr_i, addr_i, `COGR_ADDR_TEST);
  assign rd_status     = rd_i && (addr_i == `COGR_ADDR_STATUS);

  assign colour_select     = ctrl_reg[`COGR_SEL_MSB:`COGR_SEL_LSB];
  assign clock_test_enable = test_reg[`COGR_CLKTEST_BIT];

  assign status_word = {4'h0, rsvd_sel_seen, clock_test_enable, active_colour_o};

  // Offset codes; a broadcast write reaches all three colours in the same edge
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      red_offset_code <= `COGR_RST_OFFSET; // RULE1
    end
    else if (wr_ofs_all || wr_ofs_red)
    begin
      red_offset_code <= wdata_i; // RULE1 RULE4
    end
  end

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      green_offset_code <= `COGR_RST_OFFSET; // RULE2
    end
    else if (wr_ofs_all || wr_ofs_green)
    begin
      green_offset_code <= wdata_i; // RULE2 RULE4
    end
  end

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      blue_offset_code <= `COGR_RST_OFFSET; // RULE3
    end
    else if (wr_ofs_all || wr_ofs_blue)
    begin
      blue_offset_code <= wdata_i; // RULE3 RULE4
    end
  end

  // Gain codes
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      red_gain_code <= `COGR_RST_GAIN; // RULE5
    end
    else if (wr_gain_all || wr_gain_red)
    begin
      red_gain_code <= wdata_i; // RULE5 RULE8
    end
  end

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      green_gain_code <= `COGR_RST_GAIN; // RULE6
    end
    else if (wr_gain_all || wr_gain_green)
    begin
      green_gain_code <= wdata_i; // RULE6 RULE8
    end
  end

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      blue_gain_code <= `COGR_RST_GAIN; // RULE7
    end
    else if (wr_gain_all || wr_gain_blue)
    begin
      blue_gain_code <= wdata_i; // RULE7 RULE8
    end
  end

  // Control and test registers
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      ctrl_reg <= `COGR_RST_CTRL;
      test_reg <= `COGR_RST_TEST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_reg <= wdata_i;
      end
      if (wr_test)
      begin
        test_reg <= wdata_i;
      end
    end
  end

  // Reserved code keeps the last valid colour in force
  always @*
  begin
    if (colour_select == `COGR_SEL_RSVD)
    begin
      next_active_colour = active_colour_o; // RULE9
    end
    else
    begin
      next_active_colour = colour_select; // RULE9
    end
  end

  // Selected pair towards the signal path
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      active_colour_o    <= `COGR_SEL_RED;
      active_offset_o    <= `COGR_RST_OFFSET;
      active_gain_code_o <= `COGR_RST_GAIN;
    end
    else
    begin
      active_colour_o    <= next_active_colour;
      active_offset_o    <= cogr_pick(next_active_colour, red_offset_code,
                                      green_offset_code, blue_offset_code); // RULE1 RULE2 RULE3
      active_gain_code_o <= cogr_pick(next_active_colour, red_gain_code,
                                      green_gain_code, blue_gain_code); // RULE5 RULE6 RULE7
    end
  end

  // Sticky flag for a reserved selection; a new event wins over the read clear
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rsvd_sel_seen <= 1'b0;
    end
    else if (colour_select == `COGR_SEL_RSVD)
    begin
      rsvd_sel_seen <= 1'b1;
    end
    else if (rd_status)
    begin
      rsvd_sel_seen <= 1'b0;
    end
  end

  // Read data; broadcast and unmapped addresses read as zero
  always @*
  begin
    case (addr_i)
      `COGR_ADDR_CTRL:
      begin
        next_rdata = ctrl_reg;
      end
      `COGR_ADDR_TEST:
      begin
        next_rdata = test_reg;
      end
      `COGR_ADDR_OFS_RED:
      begin
        next_rdata = red_offset_code;
      end
      `COGR_ADDR_OFS_GREEN:
      begin
        next_rdata = green_offset_code;
      end
      `COGR_ADDR_OFS_BLUE:
      begin
        next_rdata = blue_offset_code;
      end
      `COGR_ADDR_GAIN_RED:
      begin
        next_rdata = red_gain_code;
      end
      `COGR_ADDR_GAIN_GREEN:
      begin
        next_rdata = green_gain_code;
      end
      `COGR_ADDR_GAIN_BLUE:
      begin
        next_rdata = blue_gain_code;
      end
      `COGR_ADDR_STATUS:
      begin
        next_rdata = status_word;
      end
      default:
      begin
        next_rdata = 8'h00; // RULE11
      end
    endcase
  end

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rdata_o <= 8'h00;
    end
    else
    begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
    end
  end

  // Applied gain value for the selected colour
  cogr_gain_calc u_gain_calc
  (
    .mclk_i       (mclk_i),
    .srst_i       (srst_i),
    .code_i       (active_gain_code_o), // RULE5 RULE6 RULE7
    .gain_milli_o (active_gain_milli_o)
  );

  // Output nibble
  cogr_out_mux u_out_mux
  (
    .mclk_i              (mclk_i),
    .srst_i              (srst_i),
    .clock_test_enable_i (clock_test_enable), // RULE10
    .conv_data_i         (conv_data_i),
    .int_sample_pulse_i  (int_sample_pulse_i),
    .video_sample_clk_i  (video_sample_clk_i),
    .converter_clk_i     (converter_clk_i),
    .reset_sample_clk_i  (reset_sample_clk_i),
    .nibble_output_o     (nibble_output_o)
  );

endmodule
`default_nettype wire

// ==== dv/cogr_regs_checker.sv ====
// Concurrent assertions for the colour offset and gain register bank
`timescale 1ns/1ps
`default_nettype none

module cogr_regs_checker
(
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        srst_i,
  // Register port
  input wire logic [3:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  // Data and timing sources
  input wire logic [3:0]  conv_data_i,
  input wire logic        int_sample_pulse_i,
  input wire logic        video_sample_clk_i,
  input wire logic        converter_clk_i,
  input wire logic        reset_sample_clk_i,
  // Applied values and pins
  input wire logic [7:0]  active_offset_o,
  input wire logic [7:0]  active_gain_code_o,
  input wire logic [13:0] active_gain_milli_o,
  input wire logic [1:0]  active_colour_o,
  input wire logic [3:0]  nibble_output_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read answer");
  a_offset_bcast_all: assert property (
    wr_i && addr_i == 4'h5 |-> ##2 active_offset_o == $past(wdata_i, 2))
    else $error("broadcast offset not applied");
  a_gain_bcast_all: assert property (
    wr_i && addr_i == 4'h9 |-> ##2 active_gain_code_o == $past(wdata_i, 2))
    else $error("broadcast gain not applied");
  a_gain_equation_ok: assert property (
    active_gain_milli_o == 14'(780 + $past(active_gain_code_o) * 7570 / 255))
    else $error("applied gain does not match code");
  a_nibble_source_ok: assert property (
    !$past(srst_i) |-> nibble_output_o == $past(conv_data_i) ||
    nibble_output_o == $past({int_sample_pulse_i, video_sample_clk_i,
                              converter_clk_i, reset_sample_clk_i}))
    else $error("nibble output from unknown source");
  a_reset_values_ok: assert property (
    $fell(srst_i) |-> active_offset_o == 8'h80 && active_gain_code_o == 8'h00
    && active_colour_o == 2'h0 && rdata_o == 8'h00)
    else $error("applied values wrong after reset");
  a_colour_never_rsvd: assert property (active_colour_o != 2'h3)
    else $error("reserved colour in force");
  a_quiet_hold_all: assert property (
    !$past(wr_i, 2) |-> $stable(active_offset_o) && $stable(active_gain_code_o)
    && $stable(active_colour_o))
    else $error("applied values moved without a write");
endmodule

bind cogr_regs cogr_regs_checker u_chk
(
  .mclk_i              (mclk_i),
  .srst_i              (srst_i),
  .addr_i              (addr_i),
  .wdata_i             (wdata_i),
  .wr_i                (wr_i),
  .rd_i                (rd_i),
  .rdata_o             (rdata_o),
  .conv_data_i         (conv_data_i),
  .int_sample_pulse_i  (int_sample_pulse_i),
  .video_sample_clk_i  (video_sample_clk_i),
  .converter_clk_i     (converter_clk_i),
  .reset_sample_clk_i  (reset_sample_clk_i),
  .active_offset_o     (active_offset_o),
  .active_gain_code_o  (active_gain_code_o),
  .active_gain_milli_o (active_gain_milli_o),
  .active_colour_o     (active_colour_o),
  .nibble_output_o     (nibble_output_o)
);

`default_nettype wire

// ==== dv/cogr_regs_test.sv ====
// Self-checking testbench for the colour offset and gain register bank
`timescale 1ns/1ps
`default_nettype none

module cogr_regs_test;
  logic        mclk_i;
  logic        srst_i;
  logic [3:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic [3:0]  conv_data_i;
  logic        int_sample_pulse_i;
  logic        video_sample_clk_i;
  logic        converter_clk_i;
  logic        reset_sample_clk_i;
  logic [7:0]  active_offset_o;
  logic [7:0]  active_gain_code_o;
  logic [13:0] active_gain_milli_o;
  logic [1:0]  active_colour_o;
  logic [3:0]  nibble_output_o;
  int          n_mismatch;
  int          tests_run;
  logic [7:0]  ofs [3];
  logic [7:0]  gn [3];

  cogr_regs u_dut
  (
    .mclk_i              (mclk_i),
    .srst_i              (srst_i),
    .addr_i              (addr_i),
    .wdata_i             (wdata_i),
    .wr_i                (wr_i),
    .rd_i                (rd_i),
    .rdata_o             (rdata_o),
    .conv_data_i         (conv_data_i),
    .int_sample_pulse_i  (int_sample_pulse_i),
    .video_sample_clk_i  (video_sample_clk_i),
    .converter_clk_i     (converter_clk_i),
    .reset_sample_clk_i  (reset_sample_clk_i),
    .active_offset_o     (active_offset_o),
    .active_gain_code_o  (active_gain_code_o),
    .active_gain_milli_o (active_gain_milli_o),
    .active_colour_o     (active_colour_o),
    .nibble_output_o     (nibble_output_o)
  );

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  function automatic logic [13:0] gexp(input logic [7:0] g);
    gexp = 14'(780 + g * 7570 / 255);
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check("rdata_o", 16'(rdata_o), 16'(exp));
  endtask

  task automatic check_active(input logic [7:0] o, input logic [7:0] g, input logic [1:0] c);
    repeat (3) @(posedge mclk_i);
    #1;
    check("active_offset_o", 16'(active_offset_o), 16'(o));
    check("active_gain_code_o", 16'(active_gain_code_o), 16'(g));
    check("active_gain_milli_o", 16'(active_gain_milli_o), 16'(gexp(g)));
    check("active_colour_o", 16'(active_colour_o), 16'(c));
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    n_mismatch = 0;
    tests_run = 0;
    srst_i = 1'b1;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    conv_data_i = 4'ha;
    int_sample_pulse_i = 1'b0;
    video_sample_clk_i = 1'b1;
    converter_clk_i = 1'b0;
    reset_sample_clk_i = 1'b1;
    ofs = '{8'h11, 8'h22, 8'h33};
    gn = '{8'h01, 8'h80, 8'hff};
    repeat (12) @(posedge mclk_i);
    srst_i <= 1'b0;
    check_active(8'h80, 8'h00, 2'h0);
    for (int i = 0; i < 3; i++)
    begin
      bus_rd(4'(2 + i), 8'h80);
      bus_rd(4'(6 + i), 8'h00);
    end
    // Distinct values per colour, then select each colour in turn
    for (int i = 0; i < 3; i++)
    begin
      bus_wr(4'(2 + i), ofs[i]);
      bus_wr(4'(6 + i), gn[i]);
    end
    for (int i = 0; i < 3; i++)
    begin
      bus_wr(4'h0, {2'h0, 2'(i), 4'h0});
      check_active(ofs[i], gn[i], 2'(i));
    end
    // Reserved code keeps blue and flags it in status
    bus_wr(4'h0, 8'h30);
    check_active(ofs[2], gn[2], 2'h2);
    bus_rd(4'ha, 8'h0a);
    bus_wr(4'h0, 8'h00);
    // Sticky flag survives until read once the code is valid again
    bus_rd(4'ha, 8'h08);
    bus_rd(4'ha, 8'h00);
    bus_wr(4'h5, 8'h5a);
    bus_wr(4'h9, 8'hc3);
    check_active(8'h5a, 8'hc3, 2'h0);
    for (int i = 0; i < 3; i++)
    begin
      bus_rd(4'(2 + i), 8'h5a);
      bus_rd(4'(6 + i), 8'hc3);
    end
    // Clock test mode swaps data for timing signals
    check("nibble_output_o", 16'(nibble_output_o), 16'h000a);
    bus_wr(4'h1, 8'h80);
    repeat (3) @(posedge mclk_i);
    #1;
    check("nibble_output_o", 16'(nibble_output_o), 16'h0005);
    @(posedge mclk_i);
    converter_clk_i <= 1'b1;
    reset_sample_clk_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    check("nibble_output_o", 16'(nibble_output_o), 16'h0006);
    bus_rd(4'h1, 8'h80);
    bus_wr(4'h1, 8'h00);
    repeat (3) @(posedge mclk_i);
    #1;
    check("nibble_output_o", 16'(nibble_output_o), 16'h000a);
    // Reset in mid-run restores the defaults
    @(posedge mclk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    check_active(8'h80, 8'h00, 2'h0);
    bus_rd(4'h4, 8'h80);
    give_verdict();
  end
endmodule

`default_nettype wire
